// ==== src/ipos_cfg.svh ====
// constants of the pending-select, source-index and sub-source stage
// assumes a 32-bit apb register bus and 32 main interrupt sources
`ifndef IPOS_CFG_SVH
`define IPOS_CFG_SVH

// register byte addresses
`define IPOS_ADDR_PEND_SEL 32'h4a000010
`define IPOS_ADDR_SRC_INDEX 32'h4a000014
`define IPOS_ADDR_SUB_PEND 32'h4a000018
`define IPOS_ADDR_SUB_MASK 32'h4a00001c
`define IPOS_ADDR_INT_STATUS 32'h4a000020
`define IPOS_ADDR_INT_MASK 32'h4a000024

// widths
`define IPOS_NUM_SRC 32
`define IPOS_IDX_W 5
`define IPOS_NUM_SUB 11
`define IPOS_NUM_PARENT 4
`define IPOS_NUM_EVT 2

// reset values
`define IPOS_PEND_SEL_RST 32'h00000000
`define IPOS_SRC_INDEX_RST 5'h00
`define IPOS_SUB_PEND_RST 11'h000
`define IPOS_SUB_MASK_RST 11'h7ff
`define IPOS_INT_STATUS_RST 2'h0
`define IPOS_INT_MASK_RST 2'h3

// implemented pending-select bits, 24 and 6 reserved
`define IPOS_SRC_VALID 32'hfeffffbf

// sub-source field positions
`define IPOS_SUB_RXD0 0
`define IPOS_SUB_TXD0 1
`define IPOS_SUB_ERR0 2
`define IPOS_SUB_RXD1 3
`define IPOS_SUB_ERR1 5
`define IPOS_SUB_RXD2 6
`define IPOS_SUB_ERR2 8
`define IPOS_SUB_TOUCH 9
`define IPOS_SUB_CONV 10

// parent request positions
`define IPOS_PAR_SERIAL0 0
`define IPOS_PAR_SERIAL1 1
`define IPOS_PAR_SERIAL2 2
`define IPOS_PAR_CONV 3

// event status positions
`define IPOS_EVT_SELECT 0
`define IPOS_EVT_SUB 1

`endif

// ==== src/ipos_pkg.sv ====
// types and shared helpers of the pending-select stage
// assumes ipos_cfg.svh on the include path
`include "ipos_cfg.svh"

package ipos_pkg;

    // apb slave phase
    typedef enum logic [0:0] {
        IPOS_IDLE = 1'b0,
        IPOS_ACCESS = 1'b1
    } ipos_apb_e;

    // state of the top module
    typedef struct packed {
        ipos_apb_e apb;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [`IPOS_NUM_SRC-1:0] pend_sel;
        logic [`IPOS_IDX_W-1:0] src_index;
        logic [`IPOS_NUM_EVT-1:0] int_status;
        logic [`IPOS_NUM_EVT-1:0] int_mask;
        logic irq;
        logic normal_irq;
    } ipos_top_s;

    // state of the sub-source bank
    typedef struct packed {
        logic [`IPOS_NUM_SUB-1:0] pend;
        logic [`IPOS_NUM_SUB-1:0] mask;
        logic [`IPOS_NUM_PARENT-1:0] parent;
        logic new_evt;
    } ipos_sub_s;

    // sticky flag update, a new set beats a same-cycle clear
    function automatic logic [31:0] ipos_w1c(input logic [31:0] cur, input logic [31:0] set,
                                             input logic [31:0] clr);
        ipos_w1c = (cur & ~clr) | set;
    endfunction

endpackage

// ==== src/ipos_sub_bank.sv ====
// sub-source pending and mask bank with parent request fan-in
// assumes requests come from logic on pclk; strobes come from the apb decode
`timescale 1ns/1ps

module ipos_sub_bank import ipos_pkg::*; #(
    parameter int NUM_SUB = `IPOS_NUM_SUB
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [NUM_SUB-1:0] sub_req,
    input wire logic clr_we,
    input wire logic [NUM_SUB-1:0] clr_data,
    input wire logic mask_we,
    input wire logic [NUM_SUB-1:0] mask_data,
    output logic [NUM_SUB-1:0] sub_pending,
    output logic [NUM_SUB-1:0] sub_mask,
    output logic [`IPOS_NUM_PARENT-1:0] parent_req,
    output logic new_evt
);

    // the parent fan-in is wired to the documented layout only
    if (NUM_SUB != `IPOS_NUM_SUB) begin : g_bad_width
        $error("ipos_sub_bank serves exactly eleven sub-sources");
    end

    ipos_sub_s st_reg;
    ipos_sub_s st_next;
    logic [NUM_SUB-1:0] live;
    logic [31:0] pend_wide;

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_next = st_reg;
        live = '0;
        // pending sets even while masked, cleared by ones written
        pend_wide = ipos_w1c(32'(st_reg.pend), 32'(sub_req), clr_we ? 32'(clr_data) : 32'h00000000);
        st_next.pend = pend_wide[NUM_SUB-1:0];
        if (mask_we) begin
            st_next.mask = mask_data;
        end
        // only unmasked pending sub-sources drive the parent requests; new_evt ignores the mask
        live = st_next.pend & ~st_next.mask;
        st_next.parent[`IPOS_PAR_SERIAL0] = |live[`IPOS_SUB_ERR0:`IPOS_SUB_RXD0];
        st_next.parent[`IPOS_PAR_SERIAL1] = |live[`IPOS_SUB_ERR1:`IPOS_SUB_RXD1];
        st_next.parent[`IPOS_PAR_SERIAL2] = |live[`IPOS_SUB_ERR2:`IPOS_SUB_RXD2];
        st_next.parent[`IPOS_PAR_CONV] = |live[`IPOS_SUB_CONV:`IPOS_SUB_TOUCH];
        // a pulse whenever a pending bit newly rises
        st_next.new_evt = |(sub_req & ~st_reg.pend);
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg.pend <= `IPOS_SUB_PEND_RST;
            st_reg.mask <= `IPOS_SUB_MASK_RST;
            st_reg.parent <= '0;
            st_reg.new_evt <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flops
    assign sub_pending = st_reg.pend;
    assign sub_mask = st_reg.mask;
    assign parent_req = st_reg.parent;
    assign new_evt = st_reg.new_evt;

endmodule // ipos_sub_bank

// ==== src/ipos_pend_offset.sv ====
// pending-select, source-index and sub-source stage of the interrupt controller
// assumes the priority stage, source pending and fast-mode select run on pclk;
// registers are reached over apb with zero wait states
`timescale 1ns/1ps

module ipos_pend_offset import ipos_pkg::*; #(
    parameter int NUM_SRC = `IPOS_NUM_SRC,
    parameter int NUM_SUB = `IPOS_NUM_SUB
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_SRC-1:0] priority_winner,
    input wire logic [NUM_SRC-1:0] source_pending,
    input wire logic [NUM_SRC-1:0] fast_mode_select,
    input wire logic [NUM_SUB-1:0] sub_source_request,
    output logic normal_irq,
    output logic [`IPOS_NUM_PARENT-1:0] sub_parent_request,
    output logic irq
);

    // the index width and reserved map fit only 32 sources
    if (NUM_SRC != `IPOS_NUM_SRC) begin : g_bad_src
        $error("ipos_pend_offset serves exactly 32 sources");
    end

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // keep only the lowest set bit so the selection is one-hot
    function automatic logic [31:0] lowest_one(input logic [31:0] v);
        lowest_one = v & (~v + 32'h00000001);
    endfunction

    // bit position of a one-hot word
    function automatic logic [`IPOS_IDX_W-1:0] encode(input logic [31:0] v);
        encode = '0;
        for (int i = 0; i < 32; i++) begin
            if (v[i]) begin
                encode = `IPOS_IDX_W'(i);
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    ipos_top_s st_reg;
    ipos_top_s st_next;
    logic [NUM_SUB-1:0] sub_pending;
    logic [NUM_SUB-1:0] sub_mask;
    logic sub_new_evt;
    logic setup;
    logic write_fire;
    logic sub_clr_we;
    logic sub_mask_we;
    logic [31:0] candidate;
    logic [31:0] chosen;
    logic [31:0] sel_clr;
    logic [31:0] evt_set;
    logic [31:0] evt_clr;
    logic [31:0] evt_wide;
    logic [31:0] rd_value;
    logic rd_error;
    logic [NUM_SRC-1:0] pend_after_clr;

    ////////////////////////////////////////////////////////////////////////////
    // apb phase decode

    // setup cycle and the access edge at which a write lands
    assign setup = psel && !penable;
    assign write_fire = (st_reg.apb == IPOS_ACCESS) && psel && penable && pwrite;
    assign sub_clr_we = write_fire && (paddr == `IPOS_ADDR_SUB_PEND);
    assign sub_mask_we = write_fire && (paddr == `IPOS_ADDR_SUB_MASK);

    ////////////////////////////////////////////////////////////////////////////
    // read mux, sampled in the setup cycle
    always_comb begin
        rd_value = 32'h00000000;
        rd_error = 1'b0;
        case (paddr)
            `IPOS_ADDR_PEND_SEL: begin
                rd_value = st_reg.pend_sel;
            end
            `IPOS_ADDR_SRC_INDEX: begin
                rd_value = 32'(st_reg.src_index);
            end
            `IPOS_ADDR_SUB_PEND: begin
                rd_value = 32'(sub_pending);
            end
            `IPOS_ADDR_SUB_MASK: begin
                rd_value = 32'(sub_mask);
            end
            `IPOS_ADDR_INT_STATUS: begin
                rd_value = 32'(st_reg.int_status);
            end
            `IPOS_ADDR_INT_MASK: begin
                rd_value = 32'(st_reg.int_mask);
            end
            default: begin
                rd_error = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_next = st_reg;
        candidate = 32'h00000000;
        chosen = 32'h00000000;
        sel_clr = 32'h00000000;
        evt_set = 32'h00000000;
        evt_clr = 32'h00000000;
        evt_wide = 32'h00000000;
        pend_after_clr = '0;

        // apb slave: answer in the access cycle, no wait states
        case (st_reg.apb)
            IPOS_IDLE: begin
                st_next.pready = 1'b0;
                st_next.pslverr = 1'b0;
                if (setup) begin
                    st_next.apb = IPOS_ACCESS;
                    st_next.pready = 1'b1;
                    st_next.pslverr = rd_error;
                    st_next.prdata = pwrite ? 32'h00000000 : rd_value;
                end
            end
            IPOS_ACCESS: begin
                st_next.apb = IPOS_IDLE;
                st_next.pready = 1'b0;
                st_next.pslverr = 1'b0;
                st_next.prdata = 32'h00000000;
            end
            default: begin
                st_next.apb = IPOS_IDLE;
                st_next.pready = 1'b0;
                st_next.pslverr = 1'b0;
            end
        endcase

        // pending-select clear by ones written, zeros leave bits alone
        if (write_fire && paddr == `IPOS_ADDR_PEND_SEL) begin
            sel_clr = pwdata;
        end
        pend_after_clr = st_reg.pend_sel & ~sel_clr;
        st_next.pend_sel = pend_after_clr;

        // source index: the register ignores every write
        // (no write path to src_index exists)

        // index drops to zero once both pending stages are clear
        if (~|pend_after_clr && !source_pending[st_reg.src_index]) begin
            st_next.src_index = `IPOS_SRC_INDEX_RST;
        end

        // capture a new normal winner only while nothing is selected
        candidate = priority_winner & ~fast_mode_select & `IPOS_SRC_VALID;
        chosen = lowest_one(candidate);
        if (~|st_reg.pend_sel && |chosen) begin
            st_next.pend_sel = chosen;
            st_next.src_index = encode(chosen);
            evt_set[`IPOS_EVT_SELECT] = 1'b1;
        end

        // the selected bit is the normal request to the core
        st_next.normal_irq = |st_next.pend_sel;

        // event status, write one to clear, set beats clear
        if (sub_new_evt) begin
            evt_set[`IPOS_EVT_SUB] = 1'b1;
        end
        if (write_fire && paddr == `IPOS_ADDR_INT_STATUS) begin
            evt_clr = pwdata;
        end
        evt_wide = ipos_w1c(32'(st_reg.int_status), evt_set, evt_clr);
        st_next.int_status = evt_wide[`IPOS_NUM_EVT-1:0];

        // event mask, a one blocks the event from the line
        if (write_fire && paddr == `IPOS_ADDR_INT_MASK) begin
            st_next.int_mask = pwdata[`IPOS_NUM_EVT-1:0];
        end

        // level interrupt while any unmasked event is pending
        st_next.irq = |(st_next.int_status & ~st_next.int_mask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg.apb <= IPOS_IDLE;
            st_reg.prdata <= 32'h00000000;
            st_reg.pready <= 1'b0;
            st_reg.pslverr <= 1'b0;
            st_reg.pend_sel <= `IPOS_PEND_SEL_RST;
            st_reg.src_index <= `IPOS_SRC_INDEX_RST;
            st_reg.int_status <= `IPOS_INT_STATUS_RST;
            st_reg.int_mask <= `IPOS_INT_MASK_RST;
            st_reg.irq <= 1'b0;
            st_reg.normal_irq <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sub-source bank
    ipos_sub_bank #(
        .NUM_SUB(NUM_SUB)
    ) u_sub_bank (
        .pclk(pclk),
        .presetn(presetn),
        .sub_req(sub_source_request),
        .clr_we(sub_clr_we),
        .clr_data(pwdata[NUM_SUB-1:0]),
        .mask_we(sub_mask_we),
        .mask_data(pwdata[NUM_SUB-1:0]),
        .sub_pending(sub_pending),
        .sub_mask(sub_mask),
        .parent_req(sub_parent_request),
        .new_evt(sub_new_evt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign normal_irq = st_reg.normal_irq;
    assign irq = st_reg.irq;

endmodule // ipos_pend_offset

// ==== sim/ipos_pend_offset_properties.sv ====
// port checker for the pending-select, source-index and sub-source stage
// assumes a bind onto ipos_pend_offset, one clock pclk and reset presetn
`include "ipos_cfg.svh"
`timescale 1ns/1ps

module ipos_checker #(
    parameter int NUM_SRC = 32,
    parameter int NUM_SUB = 11
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NUM_SRC-1:0] priority_winner,
    input wire logic [NUM_SRC-1:0] source_pending,
    input wire logic [NUM_SRC-1:0] fast_mode_select,
    input wire logic [NUM_SUB-1:0] sub_source_request,
    input wire logic normal_irq,
    input wire logic [3:0] sub_parent_request,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    localparam logic [31:0] PS = `IPOS_ADDR_PEND_SEL;
    logic [NUM_SRC-1:0] normal_win;
    logic [NUM_SRC-1:0] sel_shadow;
    logic ps_write;
    logic bad_addr;
    logic sel_hit;
    // helpers: eligible winners, select-register write, unmapped setup
    assign normal_win = priority_winner & ~fast_mode_select & `IPOS_SRC_VALID;
    assign ps_write = psel && penable && pwrite && paddr == PS;
    assign bad_addr = paddr < PS || paddr > `IPOS_ADDR_INT_MASK || paddr[1:0] != 2'h0;
    // helper: a select-register write that carries a one on the selected bit
    assign sel_hit = ps_write && |(pwdata & sel_shadow);
    // helper: the bit a new selection takes, lowest eligible winner
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_shadow <= '0;
        end else if (!normal_irq) begin
            sel_shadow <= normal_win & (~normal_win + NUM_SRC'(1));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    ready_after_setup_a:
        assert property (psel && !penable |=> pready ##1 !pready) else $error("ready not a single access cycle");
    unmapped_err_a:
        assert property (psel && !penable && bad_addr |=> pslverr && prdata == 32'h0) else $error("no error reply");
    write_reply_a:
        assert property (pready && pwrite |-> prdata == 32'h0) else $error("write returned data");
    select_raise_a:
        assert property (!normal_irq && |normal_win |=> normal_irq) else $error("winner not selected");
    fast_block_a:
        assert property (!normal_irq && normal_win == 0 |=> !normal_irq) else $error("selection without normal winner");
    select_hold_a:
        assert property (normal_irq && !sel_hit |=> normal_irq) else $error("selection lost without clear");
    clear_drop_a:
        assert property (normal_irq && sel_hit && pready |=> !normal_irq) else $error("selection not cleared");
    index_width_a:
        assert property (pready && !pwrite && paddr == `IPOS_ADDR_SRC_INDEX |-> prdata[31:5] == 27'h0)
            else $error("index out of range");
endmodule // ipos_checker

bind ipos_pend_offset ipos_checker #(.NUM_SRC(NUM_SRC), .NUM_SUB(NUM_SUB)) u_chk (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .priority_winner(priority_winner),
    .source_pending(source_pending),
    .fast_mode_select(fast_mode_select),
    .sub_source_request(sub_source_request),
    .normal_irq(normal_irq),
    .sub_parent_request(sub_parent_request),
    .irq(irq)
);

// ==== sim/ipos_src_model.sv ====
// stand-in for the main source pending and priority stages
// assumes raise and clear pulses from the bench on pclk
`timescale 1ns/1ps

module ipos_src_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [31:0] raise,
    input wire logic [31:0] clear,
    output logic [31:0] source_pending,
    output logic [31:0] priority_winner
);
    // sticky pending bits, a raise beats a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            source_pending <= 32'h0;
        end else begin
            source_pending <= (source_pending & ~clear) | raise;
        end
    end
    // no main mask here: every pending source competes
    assign priority_winner = source_pending;
endmodule // ipos_src_model

// ==== sim/ipos_pend_offset_bench.sv ====
// self-checking bench for the pending-select stage
// assumes zero-wait apb slave and the source stand-in model
`include "ipos_cfg.svh"
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end

module ipos_pend_offset_bench;
    localparam logic [31:0] PS = `IPOS_ADDR_PEND_SEL;
    localparam logic [31:0] IX = `IPOS_ADDR_SRC_INDEX;
    localparam logic [31:0] SP = `IPOS_ADDR_SUB_PEND;
    localparam logic [31:0] SM = `IPOS_ADDR_SUB_MASK;
    localparam logic [31:0] ST = `IPOS_ADDR_INT_STATUS;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = 0, pwdata = 0, fast = 0, raise = 0, clear = 0;
    logic [31:0] prdata, src_pend, winner, rd;
    logic [10:0] sub_req = 0;
    logic [3:0] parent;
    logic pready, pslverr, normal_irq, irq, last_err;
    int fails = 0, checks_done = 0, cyc = 0;
    int srcs[4] = '{0, 5, 17, 31};

    always #25 pclk = ~pclk;

    ipos_src_model u_src (.pclk(pclk), .presetn(presetn), .raise(raise), .clear(clear),
        .source_pending(src_pend), .priority_winner(winner));

    ipos_pend_offset u_dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .priority_winner(winner),
        .source_pending(src_pend),
        .fast_mode_select(fast),
        .sub_source_request(sub_req),
        .normal_irq(normal_irq),
        .sub_parent_request(parent),
        .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no timeout here, only the hang guard ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask

    // one-cycle request pulse into the source stand-in, then settle
    task automatic pulse(input logic [31:0] v);
        raise <= v;
        @(posedge pclk);
        raise <= 32'h0;
        repeat (3) @(posedge pclk);
    endtask

    task automatic clr(input logic [31:0] v);
        clear <= v;
        @(posedge pclk);
        clear <= 32'h0;
        @(posedge pclk);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values, read-only index, unmapped place
        rdchk("select rst", PS, 32'h0);
        rdchk("index rst", IX, 32'h0);
        rdchk("sub pend rst", SP, 32'h0);
        rdchk("sub mask rst", SM, 32'h7ff);
        rdchk("int mask rst", `IPOS_ADDR_INT_MASK, 32'h3);
        apb(1'b1, IX, 32'hffffffff);
        rdchk("index ro", IX, 32'h0);
        apb(1'b0, 32'h4a000028, 32'h0);
        `CHK("unmapped err", 1'b1, last_err)
        // fast source 3 and reserved sources 24 and 6 never select
        fast <= 32'h8;
        pulse(32'h01000048);
        `CHK("fast irq", 1'b0, normal_irq)
        rdchk("fast select", PS, 32'h0);
        rdchk("fast index", IX, 32'h0);
        clr(32'h01000048);
        fast <= 32'h0;
        // selection, index and service clear for sources 0, 5, 17 and 31
        foreach (srcs[i]) begin
            pulse(32'h1 << srcs[i]);
            `CHK("irq set", 1'b1, normal_irq)
            rdchk("index", IX, srcs[i]);
            rdchk("select bit", PS, 32'h1 << srcs[i]);
            clr(32'h1 << srcs[i]);
            apb(1'b1, PS, rd);
            `CHK("irq clr", 1'b0, normal_irq)
            rdchk("select clr", PS, 32'h0);
            rdchk("index clr", IX, 32'h0);
        end
        // sub-source pending, masking and parent fan-in
        sub_req <= 11'h7ff;
        @(posedge pclk);
        sub_req <= 11'h0;
        repeat (2) @(posedge pclk);
        `CHK("masked parent", 4'h0, parent)
        rdchk("sub all", SP, 32'h7ff);
        apb(1'b1, SM, 32'h5fe);
        @(posedge pclk);
        `CHK("parent fan", 4'b1001, parent)
        apb(1'b1, SP, 32'h1);
        rdchk("sub w1c", SP, 32'h7fe);
        `CHK("parent drop", 4'b1000, parent)
        apb(1'b1, SM, 32'h0);
        `CHK("parent all", 4'hf, parent)
        // event status, mask and combined interrupt
        `CHK("irq masked", 1'b0, irq)
        rdchk("status", ST, 32'h3);
        apb(1'b1, `IPOS_ADDR_INT_MASK, 32'h0);
        @(posedge pclk);
        `CHK("irq on", 1'b1, irq)
        apb(1'b1, ST, 32'h3);
        @(posedge pclk);
        `CHK("irq off", 1'b0, irq)
        rdchk("status clr", ST, 32'h0);
        report_and_stop();
    end
endmodule // ipos_pend_offset_bench
